// File: pkg/iob_pkg.sv
// Constants and carrier types for the increment, OR, move and branch execution block.
// Assumes a 14-bit instruction word and one instruction issued per enable pulse.
// Function
// - Increment-skip-if-null adds one to file register 0..127 and writes W when d is 0 or the file when d is 1, touching no status.
// - Increment-skip-if-null turns the next instruction into a no-operation when the sum is zero, taking two cycles.
// - The unconditional branch loads PC bits 10..0 from the literal and PC bits 12..11 from latch bits 4..3.
// - The unconditional branch takes a literal 0..2047, is always taken and takes two cycles.
// - OR-literal ORs W with an 8-bit literal, writes W and updates the zero flag.
// - Plain increment adds one to the file register, writes W or the file by d, and updates the zero flag.
// - OR-with-file ORs W with the file register, writes W or the file by d, and updates the zero flag.
// - The file move copies the file register to W or rewrites it unchanged, updating the zero flag from the value.
package iob_pkg;

    // ==========================================================
    // Opcode fields
    localparam logic [5:0] IOB_OP_INC_SKIP = 6'h0f;
    localparam logic [5:0] IOB_OP_INC = 6'h0a;
    localparam logic [5:0] IOB_OP_ORF = 6'h04;
    localparam logic [5:0] IOB_OP_MOVE = 6'h08;
    localparam logic [5:0] IOB_OP_ORL = 6'h38;
    localparam logic [2:0] IOB_OP_BRANCH = 3'h5;
    localparam int IOB_D_BIT = 7;
    localparam int IOB_LATCH_HI_BIT = 4;
    localparam int IOB_LATCH_LO_BIT = 3;

    // ==========================================================
    // Reset values
    localparam logic [7:0] IOB_W_RST = 8'h00;
    localparam logic [12:0] IOB_PC_RST = 13'h0000;
    localparam logic IOB_Z_RST = 1'h0;

    typedef enum {IOB_EXEC, IOB_FLUSH} iob_state_e;

    // A four-state base type lets the kind travel on nets and ports.
    typedef enum logic [2:0] {IOB_K_NONE, IOB_K_INCSZ, IOB_K_INC, IOB_K_ORF, IOB_K_MOVE, IOB_K_ORL, IOB_K_BRANCH} iob_kind_e;

    typedef struct packed {
        logic [7:0] data;
        logic [6:0] addr;
        logic we;
    } iob_file_wr_s;

endpackage : iob_pkg

// File: hw/iob_alu.sv
// Combinational result path for the block's data operations.
// Assumes the caller has already decoded the instruction kind.
module iob_alu
    import iob_pkg::*;
(
    input wire iob_kind_e kind,
    input wire logic [7:0] w_val,
    input wire logic [7:0] f_val,
    input wire logic [7:0] lit,
    output logic [7:0] result,
    output logic is_zero
);

    wire [7:0] inc_val = 8'(f_val + 8'h01);
    wire [7:0] orl_val = w_val | lit;
    wire [7:0] orf_val = w_val | f_val;

    assign result = (kind == IOB_K_INCSZ || kind == IOB_K_INC) ? inc_val :
                    (kind == IOB_K_ORL) ? orl_val :
                    (kind == IOB_K_ORF) ? orf_val : f_val;
    assign is_zero = (result == 8'h00);

endmodule // iob_alu

// File: hw/iob_exec.sv
// Execution stage for increment, OR, move and unconditional branch instructions.
// Assumes one instruction per CE pulse, the file register value supplied in the same cycle, and an external write port.
module iob_exec
    import iob_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic [13:0] INSTR,
    input wire logic [7:0] FILE_RD_DATA,
    input wire logic [7:0] PROGRAM_COUNTER_UPPER_LATCH,
    output logic [6:0] FILE_ADDR,
    output logic FILE_WE,
    output logic [7:0] FILE_WR_DATA,
    output logic [7:0] W_OUT,
    output logic Z_OUT,
    output logic Z_WE,
    output logic [12:0] PC_OUT,
    output logic BUSY
);

    // ==========================================================
    // Decode
    function automatic iob_kind_e decode(input logic [13:0] ins);
        if (ins[13:11] == IOB_OP_BRANCH) return IOB_K_BRANCH;
        if (ins[13:8] == IOB_OP_INC_SKIP) return IOB_K_INCSZ;
        if (ins[13:8] == IOB_OP_INC) return IOB_K_INC;
        if (ins[13:8] == IOB_OP_ORF) return IOB_K_ORF;
        if (ins[13:8] == IOB_OP_MOVE) return IOB_K_MOVE;
        if (ins[13:8] == IOB_OP_ORL) return IOB_K_ORL;
        return IOB_K_NONE;
    endfunction

    iob_state_e state_ff, nxt_state;
    logic [7:0] w_ff, nxt_w;
    logic z_ff, nxt_z;
    logic [12:0] pc_ff, nxt_pc;
    logic [7:0] res;
    logic res_zero;
    iob_file_wr_s fw;

    wire iob_kind_e kind = (state_ff == IOB_FLUSH) ? IOB_K_NONE : decode(INSTR);
    wire d_file = INSTR[IOB_D_BIT];
    wire is_data = kind inside {IOB_K_INCSZ, IOB_K_INC, IOB_K_ORF, IOB_K_MOVE};
    wire sets_z = kind inside {IOB_K_INC, IOB_K_ORF, IOB_K_MOVE, IOB_K_ORL};
    wire skip = CE && kind == IOB_K_INCSZ && res_zero;
    wire take = CE && kind == IOB_K_BRANCH;
    wire [12:0] branch_pc = {PROGRAM_COUNTER_UPPER_LATCH[IOB_LATCH_HI_BIT:IOB_LATCH_LO_BIT], INSTR[10:0]};

    iob_alu iob_alu_i (
        .kind(kind),
        .w_val(w_ff),
        .f_val(FILE_RD_DATA),
        .lit(INSTR[7:0]),
        .result(res),
        .is_zero(res_zero)
    );

    // ==========================================================
    // Next state
    assign fw.addr = INSTR[6:0];
    assign fw.data = res;
    assign fw.we = CE && is_data && d_file;
    assign nxt_w = (CE && ((is_data && !d_file) || kind == IOB_K_ORL)) ? res : w_ff;
    assign nxt_z = (CE && sets_z) ? res_zero : z_ff;
    assign nxt_pc = !CE ? pc_ff : take ? branch_pc : 13'(pc_ff + 13'h0001);
    // Both the skipped slot and the branch shadow are flushed, so each costs one extra cycle.
    assign nxt_state = !CE ? state_ff : (skip || take) ? IOB_FLUSH : IOB_EXEC;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            state_ff <= IOB_EXEC;
            w_ff <= IOB_W_RST;
            z_ff <= IOB_Z_RST;
            pc_ff <= IOB_PC_RST;
        end else begin
            state_ff <= nxt_state;
            w_ff <= nxt_w;
            z_ff <= nxt_z;
            pc_ff <= nxt_pc;
        end
    end

    assign FILE_ADDR = fw.addr;
    assign FILE_WE = fw.we;
    assign FILE_WR_DATA = fw.data;
    assign W_OUT = w_ff;
    assign Z_OUT = z_ff;
    assign Z_WE = CE && sets_z;
    assign PC_OUT = pc_ff;
    assign BUSY = (state_ff == IOB_FLUSH);

    // ==========================================================
    // Checks
    sequence s_incsz_zero;
        CE && kind == IOB_K_INCSZ && FILE_RD_DATA == 8'hff;
    endsequence

    AST_SKIP_FLUSH: assert property (@(posedge CLK) disable iff (!RST_B)
        s_incsz_zero |=> BUSY) else $error("zero increment did not flush next slot");
    AST_NO_SKIP: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_INCSZ && FILE_RD_DATA != 8'hff |=> !BUSY) else $error("skip without zero");
    AST_INCSZ_NOZ: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_INCSZ |=> $stable(z_ff)) else $error("skip increment touched zero flag");
    AST_BRANCH_PC: assert property (@(posedge CLK) disable iff (!RST_B)
        take |=> pc_ff == $past(branch_pc)) else $error("branch target wrong");
    AST_BRANCH_TWO: assert property (@(posedge CLK) disable iff (!RST_B)
        take |=> BUSY && !FILE_WE && !Z_WE) else $error("branch shadow not flushed");
    AST_ORL_W: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_ORL |=> w_ff == ($past(w_ff) | $past(INSTR[7:0]))) else $error("or literal wrong");
    AST_INC_WRAP: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_INC && FILE_RD_DATA == 8'hff |-> res == 8'h00 && Z_WE) else $error("increment wrap");
    AST_INC_DEST: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_INC && d_file |-> FILE_WE && FILE_WR_DATA == 8'(FILE_RD_DATA + 8'h01))
        else $error("increment file write wrong");
    AST_ORF_Z: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_ORF |=> z_ff == (($past(w_ff) | $past(FILE_RD_DATA)) == 8'h00))
        else $error("or file zero flag wrong");
    AST_MOVE_Z: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_MOVE |=> z_ff == ($past(FILE_RD_DATA) == 8'h00)) else $error("move zero flag wrong");

    // ==========================================================
    // Checks on the flushed slot
    // A write leaking out of the flushed slot would corrupt state silently, so the slot is watched on its own.
    sequence s_flush_slot;
        CE && BUSY;
    endsequence

    sequence s_branch_issue;
        CE && kind == IOB_K_BRANCH;
    endsequence

    AST_FLUSH_NOWRITE: assert property (@(posedge CLK) disable iff (!RST_B)
        s_flush_slot |-> !FILE_WE && !Z_WE)
        else $error("flushed slot wrote state");
    AST_FLUSH_ENDS: assert property (@(posedge CLK) disable iff (!RST_B)
        s_flush_slot |=> !BUSY && $stable(w_ff) && $stable(z_ff))
        else $error("flushed slot changed registers");
    AST_FLUSH_PC: assert property (@(posedge CLK) disable iff (!RST_B)
        s_flush_slot |=> pc_ff == 13'($past(pc_ff) + 13'h0001))
        else $error("flushed slot pc step wrong");

    // ==========================================================
    // Checks on the branch and on the program counter step of every other instruction
    AST_BRANCH_NOWRITE: assert property (@(posedge CLK) disable iff (!RST_B)
        s_branch_issue |-> !FILE_WE && !Z_WE)
        else $error("branch wrote data");
    AST_BRANCH_KEEP: assert property (@(posedge CLK) disable iff (!RST_B)
        s_branch_issue |=> $stable(w_ff) && $stable(z_ff))
        else $error("branch changed accumulator or flag");
    AST_PC_STEP: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind != IOB_K_BRANCH |=> pc_ff == 13'($past(pc_ff) + 13'h0001))
        else $error("pc did not advance by one");

    // ==========================================================
    // Checks on the data paths
    // Each destination is checked separately so a swapped d decode shows up on either side.
    AST_INCSZ_W: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_INCSZ && !d_file |=> w_ff == 8'($past(FILE_RD_DATA) + 8'h01))
        else $error("skip increment accumulator wrong");
    AST_INCSZ_F: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_INCSZ && d_file |-> FILE_WE && FILE_WR_DATA == 8'(FILE_RD_DATA + 8'h01) && !Z_WE)
        else $error("skip increment file write wrong");
    AST_INCSZ_KEEPW: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_INCSZ && d_file |=> $stable(w_ff))
        else $error("skip increment to file touched accumulator");
    AST_INC_W: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_INC && !d_file |=> w_ff == 8'($past(FILE_RD_DATA) + 8'h01)
        && z_ff == ($past(FILE_RD_DATA) == 8'hff))
        else $error("increment accumulator wrong");
    AST_INC_W_NOFILE: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_INC && !d_file |-> !FILE_WE && Z_WE)
        else $error("increment to accumulator wrote file");
    AST_ORL_Z: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_ORL |=> z_ff == (($past(w_ff) | $past(INSTR[7:0])) == 8'h00))
        else $error("or literal zero flag wrong");
    AST_ORL_NOFILE: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_ORL |-> !FILE_WE && Z_WE)
        else $error("or literal wrote file");
    AST_ORF_F: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_ORF && d_file |-> FILE_WE && FILE_WR_DATA == (w_ff | FILE_RD_DATA))
        else $error("or file write wrong");
    AST_ORF_W: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_ORF && !d_file |=> w_ff == ($past(w_ff) | $past(FILE_RD_DATA)))
        else $error("or file accumulator wrong");
    AST_MOVE_F: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_MOVE && d_file |-> FILE_WE && FILE_WR_DATA == FILE_RD_DATA)
        else $error("move rewrite wrong");
    AST_MOVE_W: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_MOVE && !d_file |=> w_ff == $past(FILE_RD_DATA))
        else $error("move accumulator wrong");
    AST_MOVE_KEEPW: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && kind == IOB_K_MOVE && d_file |=> $stable(w_ff))
        else $error("move test touched accumulator");

endmodule // iob_exec

// File: tb/iob_exec_tb.sv
// Self-checking bench for the increment, OR, move and branch execution stage.
// Assumes the stage issues one instruction per CE pulse and is fed file data in the same cycle.
module iob_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import iob_pkg::*;
    `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
        $display("Error at %0t: mismatch, got %h expected %h", $time, (a), (b)); end end
    logic CLK = 1'b0, RST_B = 1'b0, CE = 1'b0;
    logic [13:0] INSTR = 14'h0000;
    logic [7:0] FILE_RD_DATA = 8'h00, PROGRAM_COUNTER_UPPER_LATCH = 8'h00;
    logic [6:0] FILE_ADDR;
    logic FILE_WE, Z_OUT, Z_WE, BUSY;
    logic [7:0] FILE_WR_DATA, W_OUT;
    logic [12:0] PC_OUT, pc;
    int num_errors = 0, total_checks = 0;
    iob_exec iob_exec_i (.CLK(CLK), .RST_B(RST_B), .CE(CE), .INSTR(INSTR), .FILE_RD_DATA(FILE_RD_DATA),
        .PROGRAM_COUNTER_UPPER_LATCH(PROGRAM_COUNTER_UPPER_LATCH), .FILE_ADDR(FILE_ADDR), .FILE_WE(FILE_WE),
        .FILE_WR_DATA(FILE_WR_DATA), .W_OUT(W_OUT), .Z_OUT(Z_OUT), .Z_WE(Z_WE), .PC_OUT(PC_OUT), .BUSY(BUSY));
    always #20 CLK = ~CLK;
    // ==========================================================
    // Bus-free helpers
    function automatic logic [13:0] fop(input logic [5:0] op, input logic d, input logic [6:0] f);
        return {op, d, f};
    endfunction
    task automatic ex(input logic [13:0] i, input logic [7:0] f, input logic we, input logic [7:0] wd,
        input logic zwe);
        @(posedge CLK);
        CE <= 1'b1;
        INSTR <= i;
        FILE_RD_DATA <= f;
        #1;
        `CHK(FILE_ADDR, i[6:0])
        `CHK(FILE_WE, we)
        if (we) `CHK(FILE_WR_DATA, wd)
        `CHK(Z_WE, zwe)
        pc = pc + 13'h0001;
    endtask
    task automatic rg(input logic [7:0] w, input logic z, input logic b);
        @(posedge CLK);
        CE <= 1'b0;
        #1;
        `CHK(W_OUT, w)
        `CHK(Z_OUT, z)
        `CHK(PC_OUT, pc)
        `CHK(BUSY, b)
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_skip();
        ex(fop(IOB_OP_INC_SKIP, 1'b0, 7'h10), 8'h41, 1'b0, 8'h00, 1'b0);
        rg(8'h42, 1'b0, 1'b0);
        ex(fop(IOB_OP_INC_SKIP, 1'b1, 7'h7f), 8'hff, 1'b1, 8'h00, 1'b0);
        // The slot after a zero sum must write nothing even though it is a valid move.
        ex(fop(IOB_OP_MOVE, 1'b0, 7'h11), 8'h77, 1'b0, 8'h00, 1'b0);
        `CHK(BUSY, 1'b1)
        rg(8'h42, 1'b0, 1'b0);
    endtask
    task automatic t_inc();
        ex(fop(IOB_OP_INC, 1'b1, 7'h20), 8'hff, 1'b1, 8'h00, 1'b1);
        rg(8'h42, 1'b1, 1'b0);
        ex(fop(IOB_OP_INC, 1'b0, 7'h21), 8'h7f, 1'b0, 8'h00, 1'b1);
        rg(8'h80, 1'b0, 1'b0);
    endtask
    task automatic t_or_move();
        ex(fop(IOB_OP_MOVE, 1'b0, 7'h30), 8'h00, 1'b0, 8'h00, 1'b1);
        rg(8'h00, 1'b1, 1'b0);
        ex({IOB_OP_ORL, 8'h00}, 8'h00, 1'b0, 8'h00, 1'b1);
        ex(fop(IOB_OP_ORF, 1'b1, 7'h31), 8'h05, 1'b1, 8'h05, 1'b1);
        rg(8'h00, 1'b0, 1'b0);
        ex(fop(IOB_OP_ORF, 1'b0, 7'h32), 8'h30, 1'b0, 8'h00, 1'b1);
        ex({IOB_OP_ORL, 8'h81}, 8'h00, 1'b0, 8'h00, 1'b1);
        rg(8'hb1, 1'b0, 1'b0);
        ex(fop(IOB_OP_MOVE, 1'b1, 7'h33), 8'h55, 1'b1, 8'h55, 1'b1);
        rg(8'hb1, 1'b0, 1'b0);
    endtask
    task automatic t_branch(input logic [7:0] latch, input logic [10:0] k);
        @(posedge CLK);
        PROGRAM_COUNTER_UPPER_LATCH <= latch;
        ex({IOB_OP_BRANCH, k}, 8'h00, 1'b0, 8'h00, 1'b0);
        ex(fop(IOB_OP_INC, 1'b1, 7'h01), 8'h10, 1'b0, 8'h00, 1'b0);
        `CHK(PC_OUT, {latch[4:3], k})
        `CHK(BUSY, 1'b1)
        pc = {latch[4:3], k} + 13'h0001;
        rg(8'hb1, 1'b0, 1'b0);
    endtask
    task automatic t_corner();
        ex(fop(IOB_OP_MOVE, 1'b1, 7'h34), 8'h00, 1'b1, 8'h00, 1'b1);
        rg(8'hb1, 1'b1, 1'b0);
        // An opcode outside the subset only advances the program counter.
        ex(14'h0000, 8'h00, 1'b0, 8'h00, 1'b0);
        rg(8'hb1, 1'b1, 1'b0);
        ex(fop(IOB_OP_INC_SKIP, 1'b0, 7'h12), 8'hff, 1'b0, 8'h00, 1'b0);
        ex({IOB_OP_ORL, 8'h0f}, 8'h00, 1'b0, 8'h00, 1'b0);
        `CHK(BUSY, 1'b1)
        rg(8'h00, 1'b1, 1'b0);
    endtask
    // ==========================================================
    // Verdict and run control
    task automatic results();
        if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #(40 * 3000);
        num_errors++;
        results();
    end
    initial begin
        pc = 13'h0000;
        repeat (6) @(posedge CLK);
        RST_B <= 1'b1;
        #1;
        `CHK(W_OUT, IOB_W_RST)
        `CHK(PC_OUT, IOB_PC_RST)
        `CHK(BUSY, 1'b0)
        t_skip();
        t_inc();
        t_or_move();
        t_branch(8'h18, 11'h7ff);
        t_branch(8'he8, 11'h000);
        t_corner();
        results();
    end
endmodule // iob_exec_tb
